// ==== rtl/bbe_pkg.sv ====
// Shared constants and types for the beam blanking evaluator.
// Assumes a 125 MHz pclk; times are kept in microseconds.
package bbe_pkg;

  // Clock rate and timing figures
  localparam int unsigned CLK_MHZ        = 125;
  localparam int unsigned RESET_MIN_US   = 250000;
  localparam int unsigned RESET_MAX_US   = 2000000;
  localparam int unsigned LAMP_TEST_US   = 1000000;
  localparam int unsigned SCAN_SHOW_US   = 1000000;
  localparam int unsigned FLASH_HALF_US  = 250000;
  localparam int unsigned RESET_MIN_CYC  = RESET_MIN_US * CLK_MHZ;
  localparam int unsigned RESET_MAX_CYC  = RESET_MAX_US * CLK_MHZ;
  localparam int unsigned LAMP_TEST_CYC  = LAMP_TEST_US * CLK_MHZ;
  localparam int unsigned SCAN_SHOW_CYC  = SCAN_SHOW_US * CLK_MHZ;
  localparam int unsigned FLASH_HALF_CYC = FLASH_HALF_US * CLK_MHZ;

  // Screen geometry
  localparam int unsigned NUM_BEAMS       = 16;
  localparam int unsigned NUM_ZONES       = 8;
  localparam int unsigned TEN_BEAM_SYSTEM = 10;

  // Register map (byte addresses)
  localparam logic [7:0] ADDR_CFG    = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_BLANK  = 8'h08;
  localparam logic [7:0] ADDR_BEAMS  = 8'h0c;

  // Switch register fields
  localparam int unsigned CFG_W      = 7;
  localparam int unsigned CFG_RR1    = 0;
  localparam int unsigned CFG_TL1    = 1;
  localparam int unsigned CFG_RR2    = 2;
  localparam int unsigned CFG_TL2    = 3;
  localparam int unsigned CFG_SC_LSB = 4;
  localparam int unsigned CFG_SC_W   = 2;
  localparam int unsigned CFG_MON    = 6;
  localparam logic [CFG_W-1:0] CFG_RESET = 7'h50;

  // Status register fields
  localparam int unsigned STAT_STATE_LSB = 0;
  localparam int unsigned STAT_OUT       = 3;
  localparam int unsigned STAT_MON       = 4;
  localparam int unsigned STAT_CNT_LSB   = 8;

  // Lockout codes on the display
  localparam logic [7:0] ERR_CODE_GENERAL = 8'h01;
  localparam logic [7:0] ERR_CODE_MONITOR = 8'h02;

  typedef enum logic [2:0] {
    ST_POWERUP = 3'h0,
    ST_SCAN    = 3'h1,
    ST_RUN     = 3'h3,
    ST_LATCHED = 3'h2,
    ST_TEACH   = 3'h6,
    ST_TAUGHT  = 3'h7,
    ST_LOCKOUT = 3'h5
  } bbe_state_type;

  typedef enum logic [2:0] {
    MSG_DARK               = 3'h0,
    MSG_LAMP               = 3'h1,
    MSG_SCAN_CODE          = 3'h2,
    MSG_COUNT              = 3'h3,
    MSG_CHANNEL_ONE        = 3'h4,
    MSG_BLANK_TEACH_ACTIVE = 3'h5,
    MSG_BLANK_TEACH_DONE   = 3'h6,
    MSG_ERROR              = 3'h7
  } bbe_msg_type;

endpackage : bbe_pkg

// ==== rtl/bbe_reset_if.sv ====
// Carrier between the evaluator and its reset switch qualifier.
// Assumes both ends run on the same pclk.
`timescale 1ns/1ps
interface bbe_reset_if;
  logic switch_closed;
  logic reset_valid;
  modport qual (input switch_closed, output reset_valid);
  modport user (output switch_closed, input reset_valid);
endinterface : bbe_reset_if

// ==== rtl/bbe_reset_qualifier.sv ====
// Reset switch qualifier: pulses reset_valid after a closure of
// legal length is released. Assumes a synchronous switch level.
`timescale 1ns/1ps
module bbe_reset_qualifier
  import bbe_pkg::*;
#(
  parameter int unsigned MIN_CYCLES = RESET_MIN_CYC,
  parameter int unsigned MAX_CYCLES = RESET_MAX_CYC
)(
  input  wire logic pclk,
  input  wire logic presetn,
  bbe_reset_if.qual rst
);
  localparam int unsigned CW = $clog2(MAX_CYCLES + 2);
  localparam logic [CW-1:0] HOLD_SAT = CW'(MAX_CYCLES + 1);

  logic [CW-1:0] hold_q;
  logic          closed_q;
  logic          valid_q;

  if (MIN_CYCLES < 1 || MIN_CYCLES > MAX_CYCLES)
  begin : g_bad_window
    $error("reset window bounds out of order");
  end

  // Closure length, saturating so an overlong hold never wraps
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hold_q <= '0;
    else if (!rst.switch_closed)
      hold_q <= '0;
    else if (hold_q != HOLD_SAT)
      hold_q <= hold_q + 1'b1;
  end

  // Release edge with the length inside the window
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      closed_q <= 1'b0;
      valid_q  <= 1'b0;
    end
    else
    begin
      closed_q <= rst.switch_closed;
      valid_q  <= closed_q && !rst.switch_closed && // RULE11
                  hold_q >= CW'(MIN_CYCLES) && hold_q <= CW'(MAX_CYCLES);
    end
  end

  assign rst.reset_valid = valid_q;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_reset_window: assert property ( // RULE11
    rst.reset_valid |-> $past(hold_q) >= MIN_CYCLES &&
                        $past(hold_q) <= MAX_CYCLES &&
                        !$past(rst.switch_closed))
    else $error("reset accepted outside closure window");

endmodule : bbe_reset_qualifier

// ==== rtl/bbe_evaluator.sv ====
// Beam blanking evaluator: judges beam states, drives the paired
// safety outputs, indicators and display; APB switch/status registers.
// Assumes beam, test, reset and monitor inputs synchronous to pclk.
//
// Operation
// RULE1: Lamp test all indicators, then scan code.
// RULE2: Sync beam lost: zone one red, message.
// RULE3: Zones turn green, count drops as beams clear.
// RULE4: Test open: beams minus one, zones red.
// RULE5: Lockout flashes red status steadily.
// RULE6: Reduced resolution tolerates two adjacent blocked beams.
// RULE7: Reduced resolution run flashes green status.
// RULE8: Blanked regions anywhere except the sync beam.
// RULE9: Outputs on only while blanked beams blocked.
// RULE10: Operator sets teach switch pattern, then reset.
// RULE11: Reset closure between quarter and two seconds.
// RULE12: Teach shows alternating message, count, red status.
// RULE13: Returning switches to normal stores blocked beams.
// RULE14: Blanked beam clearing forces lockout.
// RULE15: After teach show done, flash, await reset.
// RULE16: Teaching with nothing blocked clears blanking.
// RULE17: Monitor wiring mismatch: error, refuse teaching.
// RULE18: Trip mode: red while obstruction persists.
// RULE19: Latch: reset steady while blocked, flashing clear.
// RULE20: Red zones track obstructed beam positions.
// RULE21: Clear run: green status, green zones, reset.
// RULE22: Downstream cascade obstruction shows on status.
// RULE23: Sync beam blocked: other zones dark.
// RULE24: Latch mode outputs on after clear and reset.
// RULE25: Both safety outputs switch together.
`timescale 1ns/1ps
module bbe_evaluator
  import bbe_pkg::*;
#(
  parameter int unsigned NB          = NUM_BEAMS,
  parameter int unsigned NZ          = NUM_ZONES,
  parameter int unsigned LAMP_CYCLES = LAMP_TEST_CYC,
  parameter int unsigned SCAN_CYCLES = SCAN_SHOW_CYC,
  parameter int unsigned FLASH_CYCLES = FLASH_HALF_CYC,
  parameter int unsigned RST_MIN     = RESET_MIN_CYC,
  parameter int unsigned RST_MAX     = RESET_MAX_CYC
)(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic [NB-1:0] beam_clear,
  input  wire logic          test_input_open,
  input  wire logic          reset_switch,
  input  wire logic          contact_monitor_wired,
  input  wire logic          cascade_blocked,
  output logic      [1:0]    safety_outputs,
  output logic               status_red,
  output logic               status_green,
  output logic               reset_indicator,
  output logic      [NZ-1:0] zone_red,
  output logic      [NZ-1:0] zone_green,
  output bbe_msg_type        display_msg,
  output logic      [7:0]    display_value
);
  localparam int unsigned TW = $clog2(LAMP_CYCLES + SCAN_CYCLES + 2);
  localparam int unsigned FW = $clog2(FLASH_CYCLES + 1);
  localparam logic [NB-1:0] BLANK_KEEP = {{(NB-1){1'b1}}, 1'b0};

  if (NB < NZ || NB > 32 || FLASH_CYCLES < 1)
  begin : g_bad_geometry
    $error("beam count or flash period not supported");
  end

  // Zones touched by a beam mask; beams split evenly over zones
  function automatic logic [NZ-1:0] zone_hit(input logic [NB-1:0] m);
    logic [NZ-1:0] z;
    z = '0;
    for (int b = 0; b < NB; b++)
    begin
      if (m[b]) z[(b * NZ) / NB] = 1'b1;
    end
    return z;
  endfunction : zone_hit

  function automatic logic [7:0] count_ones(input logic [NB-1:0] m);
    logic [7:0] c;
    c = '0;
    for (int b = 0; b < NB; b++)
      c = c + 8'(m[b]);
    return c;
  endfunction : count_ones

  // Three blocked in a row is the first thing the window cannot hide
  function automatic logic three_in_row(input logic [NB-1:0] m);
    logic v;
    v = 1'b0;
    for (int b = 1; b + 2 < NB; b++)
      v = v | (m[b] & m[b+1] & m[b+2]);
    return v;
  endfunction : three_in_row

  // Where a reset or the end of start-up leads
  function automatic bbe_state_type pick_state(
    input logic [CFG_W-1:0] c,
    input logic             err,
    input logic             allow_teach
  );
    logic normal;
    logic teach;
    normal = c[CFG_RR1] == c[CFG_RR2] && c[CFG_TL1] == c[CFG_TL2];
    teach  = c[CFG_RR1] && !c[CFG_TL1] && !c[CFG_RR2] && c[CFG_TL2];
    if (err)
      return ST_LOCKOUT; // RULE17
    else if (teach && allow_teach)
      return ST_TEACH;
    else if (normal)
      return c[CFG_TL1] ? ST_LATCHED : ST_RUN; // RULE24
    else
      return ST_LOCKOUT;
  endfunction : pick_state

  bbe_reset_if rst_bus ();

  bbe_reset_qualifier #(
    .MIN_CYCLES (RST_MIN),
    .MAX_CYCLES (RST_MAX)
  ) u_reset_qual (
    .pclk    (pclk),
    .presetn (presetn),
    .rst     (rst_bus.qual)
  );

  assign rst_bus.switch_closed = reset_switch;

  bbe_state_type   state_q;
  bbe_state_type   state_d;
  logic [CFG_W-1:0] cfg_q;
  logic [NB-1:0]   blank_q;
  logic [TW-1:0]   timer_q;
  logic [FW-1:0]   flash_cnt_q;
  logic            flash_q;
  logic [31:0]     prdata_q;
  logic [NB-1:0]   blocked;
  logic [NB-1:0]   unperm;
  logic            trip;
  logic            blank_viol;
  logic            mon_err;
  logic            cfg_normal;
  logic            run_ok;
  logic            any_blocked;
  logic            apb_wr;
  logic            apb_mapped;

  // Beam judgement; an open test input reads as every beam blocked
  always_comb
  begin
    blocked     = test_input_open ? '1 : ~beam_clear;
    unperm      = blocked & ~blank_q;
    any_blocked = |blocked;
    trip = blocked[0] || cascade_blocked || // RULE22
           (cfg_q[CFG_RR1] ? three_in_row(unperm) : |unperm); // RULE6
    blank_viol = |(blank_q & ~blocked); // RULE9
    mon_err    = contact_monitor_wired != cfg_q[CFG_MON]; // RULE17
    cfg_normal = cfg_q[CFG_RR1] == cfg_q[CFG_RR2] &&
                 cfg_q[CFG_TL1] == cfg_q[CFG_TL2];
    run_ok     = state_q == ST_RUN && !trip && !blank_viol &&
                 !mon_err && cfg_normal;
  end

  // Mode sequencing
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_POWERUP:
        if (timer_q >= TW'(LAMP_CYCLES)) state_d = ST_SCAN; // RULE1
      ST_SCAN:
        if (timer_q >= TW'(SCAN_CYCLES))
          state_d = pick_state(cfg_q, mon_err, 1'b1);
      ST_RUN:
        if (mon_err || blank_viol || !cfg_normal)
          state_d = ST_LOCKOUT; // RULE14
        else if (trip && cfg_q[CFG_TL1])
          state_d = ST_LATCHED;
      ST_LATCHED:
        if (mon_err || blank_viol || !cfg_normal)
          state_d = ST_LOCKOUT;
        else if (rst_bus.reset_valid && !trip)
          state_d = ST_RUN; // RULE24
      ST_TEACH:
        if (mon_err)
          state_d = ST_LOCKOUT; // RULE17
        else if (cfg_normal)
          state_d = ST_TAUGHT;
      ST_TAUGHT:
        if (rst_bus.reset_valid)
          state_d = pick_state(cfg_q, mon_err, 1'b0); // RULE15
      ST_LOCKOUT:
        if (rst_bus.reset_valid)
          state_d = pick_state(cfg_q, mon_err, 1'b1);
      default:
        state_d = ST_LOCKOUT;
    endcase
  end

  // State and start-up timer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= ST_POWERUP;
      timer_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      timer_q <= (state_d != state_q) ? '0 : timer_q + 1'b1;
    end
  end

  // Teach capture; the sync beam is never stored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      blank_q <= '0;
    else if (state_q == ST_TEACH && state_d == ST_TAUGHT)
      blank_q <= blocked & BLANK_KEEP; // RULE13 RULE8 RULE16
  end

  // Free-running flash beat shared by every blinking indicator
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flash_cnt_q <= '0;
      flash_q     <= 1'b0;
    end
    else if (flash_cnt_q >= FW'(FLASH_CYCLES - 1))
    begin
      flash_cnt_q <= '0;
      flash_q     <= !flash_q;
    end
    else
      flash_cnt_q <= flash_cnt_q + 1'b1;
  end

  // Paired outputs from one decision so they cannot disagree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      safety_outputs <= 2'b00;
    else
      safety_outputs <= {2{run_ok}}; // RULE25 RULE9
  end

  // Indicators and display, registered to keep them glitch free
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_red      <= 1'b0;
      status_green    <= 1'b0;
      reset_indicator <= 1'b0;
      zone_red        <= '0;
      zone_green      <= '0;
      display_msg     <= MSG_DARK;
      display_value   <= '0;
    end
    else
    begin
      // Live zone view shared by run, latch and teach
      display_msg   <= MSG_COUNT;
      display_value <= count_ones(blocked); // RULE3
      if (test_input_open)
      begin
        display_value <= 8'(NB - 1); // RULE4
        zone_red      <= '1;
        zone_green    <= '0;
        if (NB == TEN_BEAM_SYSTEM)
        begin
          zone_red[0]   <= 1'b0;
          zone_green[0] <= 1'b1;
        end
      end
      else if (blocked[0])
      begin
        zone_red    <= NZ'(1); // RULE23 RULE2
        zone_green  <= '0;
        display_msg <= MSG_CHANNEL_ONE;
      end
      else
      begin
        zone_red   <= zone_hit(blocked); // RULE20
        zone_green <= ~zone_hit(blocked);
      end
      status_red      <= 1'b1;
      status_green    <= 1'b0;
      reset_indicator <= 1'b1;
      unique case (state_q)
        ST_POWERUP:
        begin
          status_red      <= flash_q; // RULE1
          status_green    <= flash_q;
          reset_indicator <= flash_q;
          zone_red        <= {NZ{flash_q}};
          zone_green      <= {NZ{flash_q}};
          display_msg     <= MSG_LAMP;
          display_value   <= '1;
        end
        ST_SCAN:
        begin
          status_red      <= 1'b0;
          reset_indicator <= 1'b0;
          zone_red        <= '0;
          zone_green      <= '0;
          display_msg     <= MSG_SCAN_CODE;
          display_value   <= 8'(cfg_q[CFG_SC_LSB +: CFG_SC_W]);
        end
        ST_RUN:
          if (!trip)
          begin
            status_red   <= 1'b0; // RULE18
            status_green <= cfg_q[CFG_RR1] ? flash_q : 1'b1; // RULE7 RULE21
          end
        ST_LATCHED:
          reset_indicator <= any_blocked ? 1'b1 : flash_q; // RULE19
        ST_TEACH:
        begin
          reset_indicator <= 1'b0; // RULE12
          if (flash_q)
            display_msg <= MSG_BLANK_TEACH_ACTIVE;
        end
        ST_TAUGHT:
        begin
          status_red      <= flash_q; // RULE15
          reset_indicator <= flash_q;
          zone_red        <= zone_hit(blank_q) & {NZ{flash_q}};
          zone_green      <= '0;
          display_msg     <= MSG_BLANK_TEACH_DONE;
          display_value   <= '0;
        end
        ST_LOCKOUT:
        begin
          status_red      <= flash_q; // RULE5
          reset_indicator <= 1'b0;
          zone_red        <= '0;
          zone_green      <= '0;
          display_msg     <= MSG_ERROR;
          display_value   <= mon_err ? ERR_CODE_MONITOR : ERR_CODE_GENERAL;
        end
        default:
          status_red <= 1'b1;
      endcase
    end
  end

  // APB: zero wait states, read data captured in the setup cycle
  assign apb_wr     = psel && penable && pwrite;
  assign apb_mapped = paddr == ADDR_CFG || paddr == ADDR_STATUS ||
                      paddr == ADDR_BLANK || paddr == ADDR_BEAMS;
  assign pready     = 1'b1;
  assign pslverr    = psel && penable && !apb_mapped;
  assign prdata     = prdata_q;

  // Switch register; it steers the whole evaluator
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg_q <= CFG_RESET;
    else if (apb_wr && paddr == ADDR_CFG)
      cfg_q <= pwdata[CFG_W-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= '0;
    else if (psel && !penable)
    begin
      prdata_q <= '0;
      unique case (paddr)
        ADDR_CFG:    prdata_q[CFG_W-1:0] <= cfg_q;
        ADDR_STATUS:
        begin
          prdata_q[STAT_STATE_LSB +: 3] <= state_q;
          prdata_q[STAT_OUT]            <= safety_outputs[0];
          prdata_q[STAT_MON]            <= mon_err;
          prdata_q[STAT_CNT_LSB +: 8]   <= count_ones(blocked);
        end
        ADDR_BLANK:  prdata_q[NB-1:0] <= blank_q;
        ADDR_BEAMS:  prdata_q[NB-1:0] <= blocked;
        default:     prdata_q <= '0;
      endcase
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_sync_zone_red: assert property ( // RULE2
    state_q inside {ST_RUN, ST_LATCHED} && blocked[0] && !test_input_open
    |=> zone_red == NZ'(1) && zone_green == '0 &&
        display_msg == MSG_CHANNEL_ONE)
    else $error("sync beam loss not shown on zone one");

  a_trip_status_red: assert property ( // RULE18
    state_q == ST_RUN && trip
    |=> status_red && !status_green && safety_outputs == 2'b00)
    else $error("trip did not turn status red and outputs off");

  a_lockout_flash: assert property ( // RULE5
    state_q == ST_LOCKOUT
    |=> status_red == $past(flash_q) && !reset_indicator &&
        safety_outputs == 2'b00)
    else $error("lockout indication wrong");

  a_teach_capture: assert property ( // RULE13
    state_q == ST_TEACH && state_d == ST_TAUGHT
    |=> blank_q == ($past(blocked) & BLANK_KEEP) && state_q == ST_TAUGHT)
    else $error("teach did not store blocked beams");

  a_blank_lockout: assert property ( // RULE14
    state_q == ST_RUN && blank_viol |=> state_q == ST_LOCKOUT)
    else $error("cleared blanked beam did not lock out");

  a_latch_release: assert property ( // RULE24
    state_q == ST_LATCHED ##1 state_q == ST_RUN
    |-> $past(rst_bus.reset_valid) && !$past(trip))
    else $error("latch released without clear and reset");

  a_monitor_refuse: assert property ( // RULE17
    mon_err |=> state_q != ST_TEACH && safety_outputs == 2'b00)
    else $error("monitor mismatch did not refuse");

  a_outputs_paired: assert property ( // RULE25
    safety_outputs[0] |-> safety_outputs[1] && $past(state_q) == ST_RUN)
    else $error("safety outputs split or on outside run");

  c_teach_done: cover property (state_q == ST_TEACH ##1 state_q == ST_TAUGHT);
  c_latch_free: cover property (state_q == ST_LATCHED ##1 state_q == ST_RUN);
  c_lockout_in: cover property (state_q == ST_RUN ##1 state_q == ST_LOCKOUT);

endmodule : bbe_evaluator

// ==== sim/bbe_operator_model.sv ====
// Operator reset switch and guarded machine control stand-in.
// Assumes the same pclk as the evaluator; presses count in cycles.
`timescale 1ns/1ps
module bbe_operator_model (
  input  wire logic       pclk,
  input  wire logic [1:0] safety_outputs,
  output logic            reset_switch,
  output logic            machine_run
);
  // Machine runs only while both channels grant it
  assign machine_run = &safety_outputs;

  initial reset_switch = 1'b0;

  // Close the switch for a count of cycles, then reopen it
  task automatic press(input int unsigned cycles);
    @(posedge pclk);
    reset_switch <= 1'b1;
    repeat (cycles) @(posedge pclk);
    reset_switch <= 1'b0;
  endtask : press
endmodule : bbe_operator_model

// ==== sim/beam_blanking_evaluator_tb.sv ====
// Self-checking bench for the beam blanking evaluator.
// Assumes shortened timing parameters and zero-wait APB.
`timescale 1ns/1ps
module beam_blanking_evaluator_tb;
  import bbe_pkg::*;
  logic pclk = 0, presetn, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic pready, pslverr, e, test_input_open, cascade_blocked;
  logic contact_monitor_wired, reset_switch, status_red, status_green;
  logic reset_indicator, machine_run;
  logic [15:0] beam_clear;
  logic [1:0] safety_outputs;
  logic [7:0] zone_red, zone_green, display_value;
  bbe_msg_type display_msg;
  int fail_count = 0, checks = 0;

  always #4 pclk = ~pclk;

  bbe_evaluator #(.LAMP_CYCLES(20), .SCAN_CYCLES(20), .FLASH_CYCLES(4),
    .RST_MIN(5), .RST_MAX(40)) bbe_evaluator_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .beam_clear(beam_clear),
    .test_input_open(test_input_open), .reset_switch(reset_switch),
    .contact_monitor_wired(contact_monitor_wired),
    .cascade_blocked(cascade_blocked), .safety_outputs(safety_outputs),
    .status_red(status_red), .status_green(status_green),
    .reset_indicator(reset_indicator), .zone_red(zone_red),
    .zone_green(zone_green), .display_msg(display_msg),
    .display_value(display_value));

  bbe_operator_model bbe_operator_model_inst (.pclk(pclk),
    .safety_outputs(safety_outputs), .reset_switch(reset_switch),
    .machine_run(machine_run));

  task automatic conclude();
    if (fail_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude

  task automatic chk(input string n, input logic [31:0] x,
                     input logic [31:0] g);
    checks++;
    if (g !== x)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb

  task automatic state_is(input logic [2:0] s);
    apb(0, ADDR_STATUS, 0);
    chk("state", s, d[2:0]);
  endtask : state_is

  // Drive beams, then let the registered outputs settle
  task automatic beams(input logic [15:0] v);
    @(posedge pclk);
    beam_clear <= v;
    cyc(4);
  endtask : beams

  // Count beats of a lamp over a window; a flashing lamp shows both
  task automatic flashes(input string n, ref logic s);
    int hi;
    hi = 0;
    repeat (16) @(posedge pclk) hi += int'(s === 1'b1);
    chk(n, 1, hi > 2 && hi < 14);
  endtask : flashes

  task automatic t_powerup();
    cyc(2);
    chk("lamp msg", MSG_LAMP, display_msg);
    cyc(22);
    chk("scan msg", MSG_SCAN_CODE, display_msg);
    cyc(25);
    apb(0, ADDR_CFG, 0);
    chk("cfg reset", 32'h50, d);
    apb(0, 8'h10, 0);
    chk("unmapped err", 1, e);
    chk("unmapped data", 0, d);
    apb(1, ADDR_STATUS, 32'hff);
    state_is(ST_RUN);
    chk("green", 1, status_green & reset_indicator);
    chk("zones green", 8'hff, zone_green);
    chk("outputs on", 2'b11, safety_outputs);
    chk("machine run", 1, machine_run);
  endtask : t_powerup

  task automatic t_blocked();
    beams(~16'h0020);
    chk("red", 1, status_red & ~status_green);
    chk("zone red", 8'h04, zone_red);
    chk("count", 1, display_value);
    chk("outputs off", 2'b00, safety_outputs);
    beams(~16'h0220);
    chk("zone red two", 8'h14, zone_red);
    chk("count two", 2, display_value);
    beams(~16'h0001);
    chk("sync zones", 8'h01, zone_red | zone_green);
    chk("sync msg", MSG_CHANNEL_ONE, display_msg);
    beams(16'hffff);
    chk("cleared", 8'hff, zone_green);
    test_input_open <= 1;
    cyc(4);
    chk("test count", 15, display_value);
    chk("test zones", 8'hff, zone_red);
    test_input_open <= 0;
    cascade_blocked <= 1;
    cyc(4);
    chk("cascade red", 1, status_red);
    cascade_blocked <= 0;
    cyc(4);
  endtask : t_blocked

  task automatic t_reduced();
    apb(1, ADDR_CFG, 32'h55);
    beams(~16'h0018);
    chk("rr two held", 2'b11, safety_outputs);
    flashes("rr green", status_green);
    beams(~16'h0038);
    chk("rr three trip", 2'b00, safety_outputs);
    beams(16'hffff);
    apb(1, ADDR_CFG, 32'h50);
    cyc(4);
  endtask : t_reduced

  // Latch mode: trip holds until beams clear and a valid reset
  task automatic t_latch();
    apb(1, ADDR_CFG, 32'h5a);
    beams(~16'h0020);
    state_is(ST_LATCHED);
    chk("latch red", 1, status_red & reset_indicator);
    bbe_operator_model_inst.press(10);
    cyc(6);
    state_is(ST_LATCHED);
    beams(16'hffff);
    flashes("latch reset", reset_indicator);
    chk("latch held", 2'b00, safety_outputs);
    bbe_operator_model_inst.press(10);
    cyc(6);
    state_is(ST_RUN);
    chk("latch on", 2'b11, safety_outputs);
    apb(1, ADDR_CFG, 32'h50);
    cyc(4);
  endtask : t_latch

  task automatic t_teach(input logic [15:0] obj);
    apb(1, ADDR_CFG, 32'h59);
    cyc(4);
    state_is(ST_LOCKOUT);
    flashes("lock red", status_red);
    bbe_operator_model_inst.press(2);
    cyc(6);
    state_is(ST_LOCKOUT);
    bbe_operator_model_inst.press(10);
    cyc(6);
    state_is(ST_TEACH);
    chk("teach ind", 1, status_red & ~reset_indicator);
    beams(~obj);
    apb(1, ADDR_CFG, 32'h50);
    cyc(4);
    state_is(ST_TAUGHT);
    chk("done msg", MSG_BLANK_TEACH_DONE, display_msg);
    apb(0, ADDR_BLANK, 0);
    chk("taught set", obj, d);
    bbe_operator_model_inst.press(10);
    cyc(6);
    chk("blanked run", 2'b11, safety_outputs);
  endtask : t_teach

  initial
  begin
    presetn <= 0;
    psel <= 0;
    penable <= 0;
    pwrite <= 0;
    paddr <= 8'h00;
    pwdata <= 32'h0;
    test_input_open <= 0;
    cascade_blocked <= 0;
    contact_monitor_wired <= 1;
    beam_clear <= 16'hffff;
    cyc(12);
    presetn <= 1;
    t_powerup();
    t_blocked();
    t_reduced();
    t_latch();
    t_teach(16'h00c0);
    beams(~16'h0040);
    state_is(ST_LOCKOUT);
    chk("lock off", 2'b00, safety_outputs);
    t_teach(16'h0000);
    contact_monitor_wired <= 0;
    cyc(4);
    apb(0, ADDR_STATUS, 0);
    chk("mon err", 1, d[STAT_MON]);
    apb(1, ADDR_CFG, 32'h59);
    bbe_operator_model_inst.press(10);
    cyc(6);
    state_is(ST_LOCKOUT);
    conclude();
  end

  // Watchdog: the whole run needs well under 5000 cycles
  initial
  begin
    cyc(20000);
    fail_count++;
    conclude();
  end
endmodule : beam_blanking_evaluator_tb
